// >>> core/cbs_defs.vh
// Offsets, field positions and reset values of the bank, serial and gain configuration registers
`ifndef CBS_DEFS_VH
`define CBS_DEFS_VH

// Register indices (printed offsets are not multiples of four)
`define CBS_IDX_FIRST_BANK  8'hf6
`define CBS_IDX_SECOND_BANK 8'hf7
`define CBS_IDX_SERIAL_EXT  8'hf8
`define CBS_IDX_GAIN_EXT    8'hf9
`define CBS_ADDR_W          10

// Field positions
`define CBS_FIRST_PAGE_BIT  2
`define CBS_SECOND_CHA_BIT  0
`define CBS_SECOND_CHB_BIT  1
`define CBS_SECOND_PAGE_BIT 2
`define CBS_SYNC_MODE_BIT   0
`define CBS_DAISY_BIT       1
`define CBS_COMB_LSB        0
`define CBS_COMB_MSB        1
`define CBS_DLY_LSB         2
`define CBS_DLY_MSB         6

// Writable bit masks per register
`define CBS_FIRST_MASK      8'h04
`define CBS_SECOND_MASK     8'h07
`define CBS_SER_MASK        8'h03
`define CBS_GAIN_MASK       8'h7f

// Reset value of every field
`define CBS_RST_VAL         8'h00

`endif

// >>> core/cbs_config_regs.v
// APB register bank for coefficient bank, serial frame sync and gain detector configuration
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
`include "cbs_defs.vh"

module cbs_config_regs
(
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Coefficient bank controls
    output reg         first_filter_page_select,
    output reg         chan_a_second_filter_bank,
    output reg         chan_b_second_filter_bank,
    output reg         second_filter_page_select,
    // Serial port controls
    output reg         frame_sync_timing_mode,
    output reg         daisy_chain_master_enable,
    // Gain loop controls
    output reg  [1:0]  gain_detector_comb_order,
    output reg  [4:0]  gain_step_align_delay
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage

    // Stored copies of the four configuration bytes; unused bits stay zero
    reg  [7:0]  first_q;    // First-stage bank control byte
    reg  [7:0]  second_q;   // Second-stage bank control byte
    reg  [7:0]  serial_q;   // Serial output extra control byte
    reg  [7:0]  gain_q;     // Gain loop extra control byte

    // Next values of the stored bytes, already cut to their writable bits
    wire [7:0]  first_d;
    wire [7:0]  second_d;
    wire [7:0]  serial_d;
    wire [7:0]  gain_d;

    // Byte of the addressed register, loaded into prdata during setup
    reg  [7:0]  rd_d;

    ////////////////////////////////////////////////////////////////////////////
    // Access decode

    wire        setup;
    wire        access;
    wire        lane0;
    wire        wr_en;
    wire [9:0]  word_idx;
    wire        aligned;
    wire        hit_first;
    wire        hit_second;
    wire        hit_serial;
    wire        hit_gain;
    wire        hit_any;
    wire        wr_first;
    wire        wr_second;
    wire        wr_serial;
    wire        wr_gain;

    // Phase of the current transfer as the slave sees it
    assign setup    = psel & ~penable;
    assign access   = psel & penable;

    // Only the low byte lane carries data; a write without it changes nothing
    assign lane0    = pstrb[0];

    // The slave answers one cycle after setup, so every access phase is wait-free
    // and a write lands at the edge that ends the access phase
    assign wr_en    = access & pready & pwrite & ~pslverr & lane0;

    // Each register is one word; the word index is the byte address over four
    assign word_idx = paddr[11:2];

    // Byte offsets inside a word are refused rather than folded onto the word
    assign aligned  = (paddr[1:0] == 2'b00);

    // Word match against the register indices, widened to the index width
    assign hit_first  = aligned & (word_idx == {2'b00, `CBS_IDX_FIRST_BANK});
    assign hit_second = aligned & (word_idx == {2'b00, `CBS_IDX_SECOND_BANK});
    assign hit_serial = aligned & (word_idx == {2'b00, `CBS_IDX_SERIAL_EXT});
    assign hit_gain   = aligned & (word_idx == {2'b00, `CBS_IDX_GAIN_EXT});

    // Any mapped word; everything else answers with an error
    assign hit_any    = hit_first | hit_second | hit_serial | hit_gain;

    // Per-register write strobes, at most one of them high at a time
    assign wr_first   = wr_en & hit_first;
    assign wr_second  = wr_en & hit_second;
    assign wr_serial  = wr_en & hit_serial;
    assign wr_gain    = wr_en & hit_gain;

    ////////////////////////////////////////////////////////////////////////////
    // Write data masking

    // Bits outside a register's fields are dropped on the way in, so they read zero.
    // The two low bits of the first-stage byte belong to other logic and stay zero here.
    assign first_d  = pwdata[7:0] & `CBS_FIRST_MASK;
    assign second_d = pwdata[7:0] & `CBS_SECOND_MASK;
    assign serial_d = pwdata[7:0] & `CBS_SER_MASK;

    // Delay field is kept as written; picking 7 or 8 is left to software
    assign gain_d   = pwdata[7:0] & `CBS_GAIN_MASK;

    ////////////////////////////////////////////////////////////////////////////
    // Read mux

    // One-hot select of the addressed byte; unmapped words read as zero
    always @*
    begin
        rd_d = 8'h00;
        case (1'b1)
            hit_first:  rd_d = first_q;
            hit_second: rd_d = second_q;
            hit_serial: rd_d = serial_q;
            hit_gain:   rd_d = gain_q;
            default:    rd_d = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake

    // Ready is a one-cycle pulse; registering it from setup costs no wait state
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
        end
        else
        begin
            pready <= setup;
        end
    end

    // Error travels with ready, so a refused access never touches storage
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pslverr <= 1'b0;
        end
        else
        begin
            pslverr <= setup & ~hit_any;   // Unmapped or unaligned address
        end
    end

    // Read data is captured in setup and held through the access phase.
    // A read that follows a write at once already sees the new byte.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (setup & ~pwrite)
        begin
            prdata <= {24'h00_0000, rd_d};
        end
        else if (!psel)
        begin
            prdata <= 32'h0000_0000;       // Idle bus shows zero, not stale data
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes

    // First-stage bank control byte
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            first_q <= `CBS_RST_VAL;
        end
        else if (wr_first)
        begin
            first_q <= first_d;
        end
    end

    // Second-stage bank control byte
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            second_q <= `CBS_RST_VAL;
        end
        else if (wr_second)
        begin
            second_q <= second_d;
        end
    end

    // Serial output extra control byte
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            serial_q <= `CBS_RST_VAL;
        end
        else if (wr_serial)
        begin
            serial_q <= serial_d;
        end
    end

    // Gain loop extra control byte
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gain_q <= `CBS_RST_VAL;
        end
        else if (wr_gain)
        begin
            gain_q <= gain_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control outputs

    // Coefficient bank selects. The extra stage keeps every output flop-driven;
    // the price is that the filters see a new bank one cycle after the write.
    // Software should not swap the active bank while a filter is mid-sample.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            first_filter_page_select  <= 1'b0;
            chan_a_second_filter_bank <= 1'b0;
            chan_b_second_filter_bank <= 1'b0;
            second_filter_page_select <= 1'b0;
        end
        else
        begin
            first_filter_page_select  <= first_q[`CBS_FIRST_PAGE_BIT];
            chan_a_second_filter_bank <= second_q[`CBS_SECOND_CHA_BIT];
            chan_b_second_filter_bank <= second_q[`CBS_SECOND_CHB_BIT];
            second_filter_page_select <= second_q[`CBS_SECOND_PAGE_BIT];
        end
    end

    // Serial port mode levels; the serial engine reads them as steady levels.
    // Low sync mode pulses per word or pair, high once per sample period.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            frame_sync_timing_mode    <= 1'b0;
            daisy_chain_master_enable <= 1'b0;
        end
        else
        begin
            frame_sync_timing_mode    <= serial_q[`CBS_SYNC_MODE_BIT];
            daisy_chain_master_enable <= serial_q[`CBS_DAISY_BIT];
        end
    end

    // Gain loop settings. Comb code 3 is passed on as written; the detector
    // decides what to do with it, this bank does not refuse it.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gain_detector_comb_order  <= 2'b00;
            gain_step_align_delay     <= 5'h00;
        end
        else
        begin
            gain_detector_comb_order  <= gain_q[`CBS_COMB_MSB:`CBS_COMB_LSB];
            gain_step_align_delay     <= gain_q[`CBS_DLY_MSB:`CBS_DLY_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Usage notes
    //
    // Every access completes in two cycles, setup and one access cycle.
    // Back-to-back transfers are accepted with no idle cycle between them.
    // A write to an unmapped or unaligned word answers with an error and
    // leaves all stored bytes unchanged.
    // A write to a mapped word whose low byte strobe is clear completes without error and
    // without changing anything, so narrow writes to upper lanes are harmless.
    // Control outputs follow a write one edge after the edge that takes it:
    // that edge into the stored byte, the next one into the output flop.
    // A reset clears the stored bytes and every output at once, without a clock.
    // The alignment delay is a plain stored value; this bank does not check
    // that software chose the value that suits the use of the gain strobes.
    ////////////////////////////////////////////////////////////////////////////

endmodule // cbs_config_regs

// >>> verification/cbs_config_regs_chk.sv
// Bus timing and field checks for the configuration register bank
`timescale 1ns/100ps
module cbs_config_regs_chk
(
    // Clock, reset and APB
    input logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [3:0]  pstrb,
    // Control outputs
    input logic        first_filter_page_select, chan_a_second_filter_bank,
    input logic        chan_b_second_filter_bank, second_filter_page_select,
    input logic        frame_sync_timing_mode, daisy_chain_master_enable,
    input logic [1:0]  gain_detector_comb_order,
    input logic [4:0]  gain_step_align_delay
);
    // A completed write with the low strobe set; an error response does not leave it out
    logic wr;
    assign wr = psel & penable & pready & pwrite & pstrb[0];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready in access cycle");
    a_ready_one_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_unmapped_error: assert property (pready && !(paddr inside
        {12'h3d8, 12'h3dc, 12'h3e0, 12'h3e4}) |-> pslverr)
        else $error("no error on unmapped address");
    a_first_page_sel: assert property (wr && paddr == 12'h3d8 |-> ##2
        first_filter_page_select == $past(pwdata[2], 2)) else $error("page one wrong");
    a_second_bank_sel: assert property (wr && paddr == 12'h3dc |-> ##2
        {second_filter_page_select, chan_b_second_filter_bank, chan_a_second_filter_bank}
        == $past(pwdata[2:0], 2)) else $error("second filter bits wrong");
    a_serial_mode_sel: assert property (wr && paddr == 12'h3e0 |-> ##2
        {daisy_chain_master_enable, frame_sync_timing_mode} == $past(pwdata[1:0], 2))
        else $error("serial bits wrong");
    a_comb_order_set: assert property (wr && paddr == 12'h3e4 |-> ##2
        gain_detector_comb_order == $past(pwdata[1:0], 2)) else $error("comb order wrong");
    a_align_delay_set: assert property (wr && paddr == 12'h3e4 |-> ##2
        gain_step_align_delay == $past(pwdata[6:2], 2)) else $error("delay wrong");
    a_reset_all_zero: assert property (disable iff (1'b0) !presetn |->
        {first_filter_page_select, chan_a_second_filter_bank, chan_b_second_filter_bank,
         second_filter_page_select, frame_sync_timing_mode, daisy_chain_master_enable,
         gain_detector_comb_order, gain_step_align_delay} == 0)
        else $error("field not cleared by reset");
endmodule // cbs_config_regs_chk
bind cbs_config_regs cbs_config_regs_chk cbs_config_regs_chk_i (.*);

// >>> verification/cbs_config_regs_tb.sv
// Directed APB bench for the configuration register bank
`timescale 1ns/100ps
module cbs_config_regs_tb;
    logic        pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0, e;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, r;
    logic [3:0]  pstrb = 4'hf;
    wire  [31:0] prdata, o;
    wire         pready, pslverr;
    int          n_errors = 0, checks_done = 0;
    logic [7:0]  mk[4] = '{8'h04, 8'h07, 8'h03, 8'h7f};
    logic [1:0]  ri[11] = '{0, 0, 1, 1, 1, 2, 2, 3, 3, 3, 3};
    logic [7:0]  dv[11] = '{8'hff, 0, 8'h01, 8'h02, 8'hfc, 8'h01, 8'h02, 8'h1c, 8'h21,
                            8'h22, 8'hff};
    // Control outputs land in o at their register's byte lane and bit
    cbs_config_regs cbs_config_regs_i (.*, .first_filter_page_select(o[2]),
        .chan_a_second_filter_bank(o[8]), .chan_b_second_filter_bank(o[9]),
        .second_filter_page_select(o[10]), .frame_sync_timing_mode(o[16]),
        .daisy_chain_master_enable(o[17]), .gain_detector_comb_order(o[25:24]),
        .gain_step_align_delay(o[30:26]));
    always #5 pclk = ~pclk;
    task ck(input [32:0] g, x);
        checks_done++;
        if (g !== x)
        begin
            n_errors++;
            $display("Error %0t: got %h expected %h", $time, g, x);
        end
    endtask
    // One APB transfer; psel stays up so a caller can chain the next one
    task xf(input [11:0] a, input w, input [7:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata; e = pslverr; penable <= 0;
    endtask
    task rd(input [11:0] a, input [32:0] x);
        xf(a, 0, 0); psel <= 0; ck({e, r}, x); @(posedge pclk);
    endtask
    // Write then read back at once; outputs must already follow the write
    task wrc(input [1:0] i, input [7:0] d);
        xf(12'h3d8 + {i, 2'b0}, 1, d); xf(12'h3d8 + {i, 2'b0}, 0, 0); psel <= 0;
        ck(r, d & mk[i]); ck(o[8*i+:8] & mk[i], d & mk[i]); @(posedge pclk);
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        presetn <= 0; // Falling edge at time zero starts the asynchronous reset
        repeat (3) @(posedge pclk);
        ck(o & 32'h7f030704, 0);
        presetn <= 1;
        @(posedge pclk);
        for (int i = 0; i < 4; i++) rd(12'h3d8 + 12'(4 * i), 0);
        for (int i = 0; i < 11; i++) wrc(ri[i], dv[i]);
        pstrb <= 0;
        xf(12'h3d8, 1, 8'hff);
        pstrb <= 4'hf;
        rd(12'h3d8, 0);
        rd(12'h3e8, {1'b1, 32'h0});
        rd(12'h3d9, {1'b1, 32'h0});
        presetn <= 0;
        @(posedge pclk);
        ck(o & 32'h7f030704, 0);
        presetn <= 1;
        @(posedge pclk);
        rd(12'h3e4, 0);
        end_of_test;
    end
    // Watchdog against a missing ready
    initial
    begin
        repeat (1000) @(posedge pclk);
        n_errors++;
        end_of_test;
    end
endmodule // cbs_config_regs_tb
